/* logic/ppio_top.sv */
// positioning control and i/o handshake of a pulse-train servo drive
// assumes pins from outside the clock domain and a register port on ref_clk_i
//
// The implementer's own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module ppio_top #(
    parameter int unsigned MS_TICK_CYCLES = ppio_pkg::MS_CYCLES,
    parameter int unsigned SETTLE_TICKS = ppio_pkg::SETTLE_CYCLES
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire ppio_pkg::ppio_pins_t pins_i,
    input wire ppio_pkg::ppio_bus_t bus_i,
    output logic [31:0] rdata_o,
    output logic ready_o,
    output logic move_o,
    output logic end_o,
    output logic near_o,
    output logic brake_timing_output_o,
    output logic motor_enable_o,
    output logic shaft_cw_o,
    output logic nv_write_o,
    output logic position_clock_o,
    output logic alarm_o
);
    import ppio_pkg::*;

    if (MS_TICK_CYCLES < 2 || SETTLE_TICKS < 1 || SETTLE_TICKS > 65535)
    begin : g_chk
        $error("ppio_top timing parameters out of range");
    end

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [GEAR_W-1:0] gear_a_pend;
        logic [GEAR_W-1:0] gear_b_pend;
        logic dir_pend;
        logic single_pend;
        logic [GEAR_W-1:0] gear_a;
        logic [GEAR_W-1:0] gear_b;
        logic dir_sense;
        logic single_mode;
        logic abs_en;
        logic excite_nc;
        logic tool_busy;
        logic sel_move;
        logic sel_near;
        logic sel_brake;
        logic [15:0] move_min;
        logic [15:0] end_band;
        logic [15:0] near_band;
        logic [31:0] preset;
        logic gear_alarm;
        logic mp_err;
        ppio_exc_t exc;
        logic [15:0] settle_cnt;
        logic [2:0] boot_cnt;
        logic [31:0] cmd_pos;
        logic [31:0] dev;
        logic [31:0] snapshot;
        logic [31:0] ms_cnt;
        logic pulse_seen;
        logic moving;
        logic [15:0] move_cnt;
        logic clr_prev;
        logic home_prev;
        logic fb_prev;
        logic ready;
        logic move_out;
        logic end_out;
        logic near_out;
        logic brake_out;
        logic shaft_cw;
        logic nv_write;
        logic pclk;
        logic [31:0] rdata;
    } ppio_state_t;

    ppio_state_t s;
    ppio_state_t next_s;

    // ------------------------------------------------------------------
    // pin synchronisation and pulse decode
    // ------------------------------------------------------------------
    logic [$bits(ppio_pins_t)-1:0] pin_q;
    ppio_pins_t pin;
    logic cmd_fwd;
    logic cmd_rev;

    ppio_sync #(
        .W($bits(ppio_pins_t))
    ) u_sync (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .d_i(pins_i),
        .q_o(pin_q)
    );

    assign pin = ppio_pins_t'(pin_q);

    ppio_pulse u_pulse (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .single_mode_i(s.single_mode),
        .step_i(pin.step_pulse_input),
        .aux_i(pin.ccw_or_dir),
        .fwd_o(cmd_fwd),
        .rev_o(cmd_rev)
    );

    // |dev| within band, deviation is held in units of 1/gear_b
    function automatic logic in_band(input logic [31:0] d, input logic [15:0] band,
                                     input logic [GEAR_W-1:0] b);
        logic [32:0] mag;
        logic [32:0] lim;
        mag = d[31] ? (33'h0 - {d[31], d}) : {1'b0, d};
        lim = {17'h0, band} * {23'h0, b};
        in_band = mag <= lim;
    endfunction

    // ------------------------------------------------------------------
    // combinational conditions
    // ------------------------------------------------------------------
    logic exc_req;
    logic alarm;
    logic energise;
    logic clr_dev;
    logic clr_rise;
    logic ready_now;
    logic accept;
    logic fb_fwd;
    logic fb_rev;
    logic ms_tick;
    logic restart;
    logic mp_warn;
    logic gear_warn;
    logic [33:0] dev_sum;
    logic [33:0] cmd_delta;
    logic [33:0] fb_delta;

    assign exc_req = s.excite_nc ? ~pin.excite_req : pin.excite_req;
    assign alarm = s.gear_alarm | s.mp_err;
    assign energise = exc_req & pin.main_power & ~pin.shaft_free & ~alarm;
    assign mp_warn = exc_req & ~pin.main_power;
    assign gear_warn = ~gear_ok(s.gear_a_pend, s.gear_b_pend);
    assign clr_dev = pin.deviation_clear_input & ~pin.position_req;
    assign clr_rise = pin.deviation_clear_input & ~s.clr_prev;
    assign ready_now = pin.main_power & ~alarm & (s.exc == EXC_ON) & ~pin.shaft_free
        & ~clr_dev & ~s.tool_busy;
    assign accept = ready_now & (cmd_fwd | cmd_rev);
    assign fb_fwd = pin.fb_step & ~s.fb_prev & pin.fb_dir;
    assign fb_rev = pin.fb_step & ~s.fb_prev & ~pin.fb_dir;
    assign ms_tick = s.ms_cnt == 32'(MS_TICK_CYCLES - 1);
    assign restart = (s.boot_cnt == 3'h1)
        | (bus_i.wr & (bus_i.addr == ADDR_CMD) & bus_i.wdata[CMD_RESTART_BIT]);

    // one command pulse is gear_a base units, one feedback step gear_b
    assign cmd_delta = !accept ? 34'h0 : cmd_fwd ? {24'h0, s.gear_a}
        : 34'h0 - {24'h0, s.gear_a};
    assign fb_delta = fb_fwd ? {24'h0, s.gear_b} : fb_rev ? 34'h0 - {24'h0, s.gear_b}
        : 34'h0;
    assign dev_sum = {{2{s.dev[31]}}, s.dev} + cmd_delta - fb_delta;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb
    begin
        next_s = s;
        next_s.clr_prev = pin.deviation_clear_input;
        next_s.home_prev = pin.home_set;
        next_s.fb_prev = pin.fb_step;
        next_s.nv_write = 1'b0;
        next_s.pclk = 1'b0;
        next_s.rdata = 32'h0;
        if (s.boot_cnt != 3'h0)
            next_s.boot_cnt = s.boot_cnt - 3'h1;

        // register writes
        if (bus_i.wr)
        begin
            case (bus_i.addr)
                ADDR_GEAR:
                begin
                    next_s.gear_a_pend = bus_i.wdata[GEAR_W-1:0];
                    next_s.gear_b_pend = bus_i.wdata[GEAR_B_LSB +: GEAR_W];
                end
                ADDR_SYS:
                begin
                    next_s.dir_pend = bus_i.wdata[SYS_DIR_BIT];
                    next_s.single_pend = bus_i.wdata[SYS_SINGLE_BIT];
                end
                ADDR_APP:
                begin
                    next_s.excite_nc = bus_i.wdata[APP_NC_BIT];
                    next_s.tool_busy = bus_i.wdata[APP_BUSY_BIT];
                    next_s.sel_move = bus_i.wdata[APP_SEL_MOVE_BIT];
                    next_s.sel_near = bus_i.wdata[APP_SEL_NEAR_BIT];
                    next_s.sel_brake = bus_i.wdata[APP_SEL_BRAKE_BIT];
                end
                ADDR_MOVE_MIN: next_s.move_min = bus_i.wdata[15:0];
                ADDR_END_BAND: next_s.end_band = bus_i.wdata[15:0];
                ADDR_NEAR_BAND: next_s.near_band = bus_i.wdata[15:0];
                ADDR_PRESET: next_s.preset = bus_i.wdata;
                default: next_s.rdata = 32'h0;
            endcase
        end

        // register reads, data stand one cycle later
        if (bus_i.rd)
        begin
            case (bus_i.addr)
                ADDR_GEAR: next_s.rdata = {6'h0, s.gear_b_pend, 6'h0, s.gear_a_pend};
                ADDR_SYS: next_s.rdata = {30'h0, s.single_pend, s.dir_pend};
                ADDR_APP: next_s.rdata = {27'h0, s.sel_brake, s.sel_near, s.sel_move,
                    s.tool_busy, s.excite_nc};
                ADDR_MOVE_MIN: next_s.rdata = {16'h0, s.move_min};
                ADDR_END_BAND: next_s.rdata = {16'h0, s.end_band};
                ADDR_NEAR_BAND: next_s.rdata = {16'h0, s.near_band};
                ADDR_PRESET: next_s.rdata = s.preset;
                ADDR_STATUS: next_s.rdata = {20'h0, s.exc == EXC_ON, s.abs_en, s.mp_err,
                    mp_warn, s.gear_alarm, gear_warn, s.brake_out, s.near_out,
                    s.end_out, s.move_out, s.ready, alarm};
                ADDR_POSITION: next_s.rdata = s.cmd_pos;
                ADDR_DEVIATION: next_s.rdata = s.dev;
                ADDR_SNAPSHOT: next_s.rdata = s.snapshot;
                ADDR_GEAR_EFF: next_s.rdata = {6'h0, s.gear_b, 6'h0, s.gear_a};
                default: next_s.rdata = 32'h0;
            endcase
        end

        // excitation sequence
        case (s.exc)
            EXC_OFF:
            begin
                if (energise)
                begin
                    next_s.exc = EXC_SETTLE;
                    next_s.settle_cnt = 16'(SETTLE_TICKS - 1);
                end
            end
            EXC_SETTLE:
            begin
                if (!energise)
                    next_s.exc = EXC_OFF;
                else if (s.settle_cnt == 16'h0)
                    next_s.exc = EXC_ON;
                else
                    next_s.settle_cnt = s.settle_cnt - 16'h1;
            end
            EXC_ON:
            begin
                if (!energise)
                    next_s.exc = EXC_OFF;
            end
            default: next_s.exc = EXC_OFF;
        endcase

        // faults: a new error wins over a reset in the same cycle
        if (clr_rise & alarm & ~pin.position_req)
            next_s.mp_err = 1'b0;
        if (mp_warn & (cmd_fwd | cmd_rev))
            next_s.mp_err = 1'b1;

        // position clock capture
        if (clr_rise & pin.position_req)
        begin
            next_s.snapshot = s.cmd_pos;
            next_s.pclk = 1'b1;
        end

        // command position
        if (accept)
            next_s.cmd_pos = cmd_fwd ? s.cmd_pos + 32'h1 : s.cmd_pos - 32'h1;
        if (accept)
            next_s.shaft_cw = cmd_fwd ? s.dir_sense : ~s.dir_sense;
        if (pin.home_set & ~s.home_prev)
        begin
            next_s.cmd_pos = s.preset;
            next_s.nv_write = s.abs_en;
        end

        // deviation counter
        if ((s.exc == EXC_OFF) | clr_dev | pin.shaft_free)
            next_s.dev = 32'h0;
        else if (dev_sum[33] & ~dev_sum[31])
            next_s.dev = 32'h80000000;
        else if (~dev_sum[33] & (dev_sum[32] | dev_sum[31]))
            next_s.dev = 32'h7fffffff;
        else
            next_s.dev = dev_sum[31:0];

        // motion tracking on a millisecond enable
        next_s.ms_cnt = ms_tick ? 32'h0 : s.ms_cnt + 32'h1;
        if (accept | fb_fwd | fb_rev)
        begin
            next_s.pulse_seen = 1'b1;
            next_s.moving = 1'b1;
            next_s.move_cnt = s.move_min;
        end
        else if (ms_tick)
        begin
            next_s.pulse_seen = 1'b0;
            next_s.moving = s.pulse_seen;
            if (s.move_cnt != 16'h0)
                next_s.move_cnt = s.move_cnt - 16'h1;
        end

        // status outputs
        next_s.ready = ready_now;
        next_s.move_out = s.sel_move & (s.moving | (s.move_cnt != 16'h0));
        next_s.end_out = (next_s.exc == EXC_ON) & ~s.moving
            & in_band(s.dev, s.end_band, s.gear_b);
        next_s.near_out = s.sel_near & (next_s.exc == EXC_ON) & ~s.moving
            & in_band(s.dev, s.near_band, s.gear_b);
        next_s.brake_out = s.sel_brake & ((s.exc == EXC_ON) | pin.shaft_free);

        // power-up or restart command: load pending gears or escalate the warning; direction and pulse mode always load
        if (restart)
        begin
            if (gear_warn)
                next_s.gear_alarm = 1'b1;
            else
            begin
                next_s.gear_alarm = 1'b0;
                next_s.gear_a = s.gear_a_pend;
                next_s.gear_b = s.gear_b_pend;
            end
            next_s.dir_sense = s.dir_pend;
            next_s.single_mode = s.single_pend;
            next_s.abs_en = pin.absolute_enable_switch;
            if (!pin.absolute_enable_switch)
                next_s.cmd_pos = 32'h0;
            next_s.dev = 32'h0;
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            s <= '0;
            s.gear_a_pend <= GEAR_RST;
            s.gear_b_pend <= GEAR_RST;
            s.gear_a <= GEAR_RST;
            s.gear_b <= GEAR_RST;
            s.dir_pend <= DIR_RST;
            s.dir_sense <= DIR_RST;
            {s.sel_brake, s.sel_near, s.sel_move, s.tool_busy, s.excite_nc} <= APP_RST;
            s.move_min <= MOVE_MIN_RST;
            s.end_band <= END_BAND_RST;
            s.near_band <= NEAR_BAND_RST;
            s.exc <= EXC_OFF;
            s.boot_cnt <= 3'(BOOT_CYCLES);
        end
        else
            s <= next_s;
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign rdata_o = s.rdata;
    assign ready_o = s.ready;
    assign move_o = s.move_out;
    assign end_o = s.end_out;
    assign near_o = s.near_out;
    assign brake_timing_output_o = s.brake_out;
    assign motor_enable_o = s.exc != EXC_OFF;
    assign shaft_cw_o = s.shaft_cw;
    assign nv_write_o = s.nv_write;
    assign position_clock_o = s.pclk;
    assign alarm_o = s.gear_alarm | s.mp_err;
endmodule

`default_nettype wire

/* logic/ppio_pkg.sv */
// shared constants, carriers and helpers of the pulse positioning i/o block
// assumes a single 200 MHz clock and a synchronous active-high reset
`default_nettype none

package ppio_pkg;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ = 200_000_000;
    localparam int unsigned MS_CYCLES = CLK_HZ / 1000;
    localparam int unsigned SETTLE_US = 10;
    localparam int unsigned SETTLE_CYCLES = SETTLE_US * (CLK_HZ / 1_000_000);
    localparam int unsigned BOOT_CYCLES = 5;

    // ------------------------------------------------------------------
    // resolution limits
    // ------------------------------------------------------------------
    localparam int unsigned RES_BASE = 1000;
    localparam int unsigned RES_MIN = 100;
    localparam int unsigned RES_MAX = 100_000;
    localparam int unsigned GEAR_W = 10;

    // ------------------------------------------------------------------
    // register word addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_GEAR = 8'h00;
    localparam logic [7:0] ADDR_SYS = 8'h04;
    localparam logic [7:0] ADDR_APP = 8'h08;
    localparam logic [7:0] ADDR_MOVE_MIN = 8'h0c;
    localparam logic [7:0] ADDR_END_BAND = 8'h10;
    localparam logic [7:0] ADDR_NEAR_BAND = 8'h14;
    localparam logic [7:0] ADDR_PRESET = 8'h18;
    localparam logic [7:0] ADDR_CMD = 8'h1c;
    localparam logic [7:0] ADDR_STATUS = 8'h20;
    localparam logic [7:0] ADDR_POSITION = 8'h24;
    localparam logic [7:0] ADDR_DEVIATION = 8'h28;
    localparam logic [7:0] ADDR_SNAPSHOT = 8'h2c;
    localparam logic [7:0] ADDR_GEAR_EFF = 8'h30;

    // field positions
    localparam int unsigned GEAR_B_LSB = 16;
    localparam int unsigned SYS_DIR_BIT = 0;
    localparam int unsigned SYS_SINGLE_BIT = 1;
    localparam int unsigned APP_NC_BIT = 0;
    localparam int unsigned APP_BUSY_BIT = 1;
    localparam int unsigned APP_SEL_MOVE_BIT = 2;
    localparam int unsigned APP_SEL_NEAR_BIT = 3;
    localparam int unsigned APP_SEL_BRAKE_BIT = 4;
    localparam int unsigned CMD_RESTART_BIT = 0;

    // values after reset
    localparam logic [GEAR_W-1:0] GEAR_RST = 10'h001;
    localparam logic DIR_RST = 1'b1;
    localparam logic [15:0] MOVE_MIN_RST = 16'h000a;
    localparam logic [15:0] END_BAND_RST = 16'h000a;
    localparam logic [15:0] NEAR_BAND_RST = 16'h0032;
    localparam logic [4:0] APP_RST = 5'h1c;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic step_pulse_input;
        logic ccw_or_dir;
        logic fb_step;
        logic fb_dir;
        logic excite_req;
        logic deviation_clear_input;
        logic position_req;
        logic home_set;
        logic shaft_free;
        logic main_power;
        logic absolute_enable_switch;
    } ppio_pins_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } ppio_bus_t;

    typedef enum logic [2:0] {
        EXC_OFF = 3'b001,
        EXC_SETTLE = 3'b010,
        EXC_ON = 3'b100
    } ppio_exc_t;

    // resolution 1000*b/a within the permitted span
    function automatic logic gear_ok(input logic [GEAR_W-1:0] a, input logic [GEAR_W-1:0] b);
        logic [31:0] a32;
        logic [31:0] b32;
        a32 = {22'h0, a};
        b32 = {22'h0, b};
        gear_ok = (a != '0) && (b != '0)
            && (b32 * (RES_BASE / RES_MIN) >= a32)
            && (b32 <= a32 * (RES_MAX / RES_BASE));
    endfunction

endpackage

`default_nettype wire

/* logic/ppio_sync.sv */
// three-stage synchroniser for pin levels
// a change is taken once the second and third stages agree
`timescale 1ns/1ps
`default_nettype none

module ppio_sync #(
    parameter int W = 1
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } ppio_sync_t;

    ppio_sync_t s;
    ppio_sync_t next_s;

    if (W < 1)
    begin : g_chk
        $error("ppio_sync width must be positive");
    end

    always_comb
    begin
        next_s = s;
        next_s.s1 = d_i;
        next_s.s2 = s.s1;
        next_s.s3 = s.s2;
        next_s.q = (s.s3 & ~(s.s2 ^ s.s3)) | (s.q & (s.s2 ^ s.s3));
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
            s <= '0;
        else
            s <= next_s;
    end

    assign q_o = s.q;
endmodule

`default_nettype wire

/* logic/ppio_pulse.sv */
// command pulse decoder: turns synchronised pulse lines into
// one-cycle forward and reverse events for single- or two-pulse input
`timescale 1ns/1ps
`default_nettype none

module ppio_pulse (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic single_mode_i,
    input wire logic step_i,
    input wire logic aux_i,
    output logic fwd_o,
    output logic rev_o
);
    typedef struct packed {
        logic step_prev;
        logic aux_prev;
        logic fwd;
        logic rev;
    } ppio_pulse_t;

    ppio_pulse_t s;
    ppio_pulse_t next_s;
    logic step_rise;
    logic aux_rise;

    assign step_rise = step_i & ~s.step_prev;
    assign aux_rise = aux_i & ~s.aux_prev;

    always_comb
    begin
        next_s = s;
        next_s.step_prev = step_i;
        next_s.aux_prev = aux_i;
        if (single_mode_i)
        begin
            // step line carries pulses, aux line is the sense level
            next_s.fwd = step_rise & aux_i;
            next_s.rev = step_rise & ~aux_i;
        end
        else
        begin
            // simultaneous edges on both lines cancel
            next_s.fwd = step_rise & ~aux_rise;
            next_s.rev = aux_rise & ~step_rise;
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
            s <= '0;
        else
            s <= next_s;
    end

    assign fwd_o = s.fwd;
    assign rev_o = s.rev;
endmodule

`default_nettype wire

/* sim/ppio_checker.sv */
// port assertions of the pulse positioning i/o block
// assumes the bench holds pins for many cycles
`timescale 1ns/1ps
`default_nettype none
module ppio_checker (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire ppio_pkg::ppio_pins_t pins_i,
    input wire ppio_pkg::ppio_bus_t bus_i,
    input wire logic [31:0] rdata_o,
    input wire logic ready_o,
    input wire logic end_o,
    input wire logic brake_timing_output_o,
    input wire logic motor_enable_o,
    input wire logic nv_write_o,
    input wire logic position_clock_o,
    input wire logic alarm_o
);
    import ppio_pkg::*;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    // [*8] leaves room for the pin synchronisers
    chk_no_power_idle: assert property (!pins_i.main_power [*8] |=> !ready_o)
        else $error("ready without main power");
    chk_free_cuts: assert property (pins_i.shaft_free [*8] |=> !motor_enable_o && !ready_o)
        else $error("motor energised while free");
    chk_clear_blocks: assert property
        ((pins_i.deviation_clear_input && !pins_i.position_req) [*8] |=> !ready_o)
        else $error("ready while clear held");
    chk_alarm_blocks: assert property (alarm_o [*2] |-> !ready_o)
        else $error("ready during alarm");
    chk_brake_late: assert property
        ($rose(brake_timing_output_o) |-> !motor_enable_o || $past(motor_enable_o, 4))
        else $error("brake released early");
    chk_nv_store: assert property
        (nv_write_o |-> pins_i.home_set && pins_i.absolute_enable_switch)
        else $error("store without absolute mode");
    chk_pclk_cause: assert property
        (position_clock_o |-> pins_i.position_req && pins_i.deviation_clear_input)
        else $error("position clock without request");
    chk_end_excited: assert property (end_o |-> motor_enable_o)
        else $error("in position while not excited");
    chk_read_slot: assert property (rdata_o != 32'h0 |-> $past(bus_i.rd))
        else $error("read data outside its slot");
    cover property ($rose(ready_o));
    cover property (nv_write_o);
    cover property (position_clock_o);
endmodule
bind ppio_top ppio_checker chk (.ref_clk_i, .rst_i, .pins_i, .bus_i, .rdata_o, .ready_o,
    .end_o, .brake_timing_output_o, .motor_enable_o, .nv_write_o, .position_clock_o, .alarm_o);
`default_nettype wire

/* sim/ppio_ctrl_model.sv */
// controller model driving the two-pulse command lines
// assumes ready_i is the block's ready output
`timescale 1ns/1ps
`default_nettype none
module ppio_ctrl_model (
    input wire logic ref_clk_i,
    input wire logic ready_i,
    output logic cw_o,
    output logic ccw_o
);
    initial
    begin
        cw_o = 1'b0;
        ccw_o = 1'b0;
    end
    // blind sends ignore ready, only when a test asks for it
    task automatic send(input int n, input logic fwd, input logic blind);
        repeat (n)
        begin
            if (!blind && ready_i !== 1'b1)
                return;
            @(posedge ref_clk_i);
            cw_o <= fwd;
            ccw_o <= !fwd;
            repeat (5) @(posedge ref_clk_i);
            cw_o <= 1'b0;
            ccw_o <= 1'b0;
            repeat (5) @(posedge ref_clk_i);
        end
    endtask
endmodule
`default_nettype wire

/* sim/ppio_top_test.sv */
// self-checking bench of the pulse positioning i/o block
// assumes shortened tick parameters
`timescale 1ns/1ps
`default_nettype none
module ppio_top_test;
    import ppio_pkg::*;
    logic ref_clk_i, rst_i = 1'b1, exc = 0, clr = 0, preq = 0, home = 0, free = 0;
    logic mp = 1, absw = 1, cw, ccw;
    ppio_bus_t bus = '0;
    ppio_pins_t pins;
    logic [31:0] rdata_o, d, p0;
    logic ready_o, end_o, brake_timing_output_o, motor_enable_o, shaft_cw_o, move_o, near_o;
    logic nv_write_o, position_clock_o, alarm_o;
    int error_cnt = 0, checks = 0, nv_seen = 0, pc_seen = 0;
    assign pins = '{cw, ccw, 1'b0, 1'b0, exc, clr, preq, home, free, mp, absw};
    ppio_top #(.MS_TICK_CYCLES(20), .SETTLE_TICKS(4)) dut (.ref_clk_i, .rst_i, .pins_i(pins),
        .bus_i(bus), .rdata_o, .ready_o, .move_o, .end_o, .near_o, .brake_timing_output_o,
        .motor_enable_o, .shaft_cw_o, .nv_write_o, .position_clock_o, .alarm_o);
    ppio_ctrl_model ctrl (.ref_clk_i, .ready_i(ready_o), .cw_o(cw), .ccw_o(ccw));
    initial
    begin
        ref_clk_i = 1'b0;
        forever #2.5 ref_clk_i = ~ref_clk_i;
    end
    always @(posedge ref_clk_i) if (nv_write_o === 1'b1) nv_seen++;
    always @(posedge ref_clk_i) if (position_clock_o === 1'b1) pc_seen++;
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge ref_clk_i);
        bus.addr <= a;
        bus.wdata <= v;
        bus.wr <= 1'b1;
        @(posedge ref_clk_i);
        bus.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge ref_clk_i);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge ref_clk_i);
        bus.rd <= 1'b0;
        #1 v = rdata_o;
        @(posedge ref_clk_i);
    endtask
    task automatic restart();
        wr(ADDR_CMD, 32'h1);
        repeat (12) @(posedge ref_clk_i);
    endtask
    task automatic t_move();
        rd(ADDR_GEAR, d);
        chk("gear reset", 32'h00010001, d);
        rd(8'h3c, d);
        chk("unmapped", 32'h0, d);
        rd(ADDR_POSITION, p0);
        ctrl.send(2, 1'b1, 1'b1);
        rd(ADDR_POSITION, d);
        chk("idle position", p0, d);
        exc <= 1'b1;
        repeat (40) @(posedge ref_clk_i);
        chk("ready brake", 32'h7, {29'h0, ready_o, motor_enable_o, brake_timing_output_o});
        ctrl.send(3, 1'b1, 1'b0);
        ctrl.send(1, 1'b0, 1'b0);
        repeat (8) @(posedge ref_clk_i);
        rd(ADDR_POSITION, d);
        chk("position", p0 + 32'h2, d);
        chk("shaft sense", 32'h0, {31'h0, shaft_cw_o});
        repeat (60) @(posedge ref_clk_i);
        chk("end near move", 32'h7, {29'h0, end_o, near_o, move_o});
        repeat (150) @(posedge ref_clk_i);
        chk("move off", 32'h0, {31'h0, move_o});
        $display("move test done");
    endtask
    task automatic t_clear_home();
        clr <= 1'b1;
        repeat (10) @(posedge ref_clk_i);
        chk("ready on clear", 32'h0, {31'h0, ready_o});
        ctrl.send(2, 1'b1, 1'b1);
        rd(ADDR_DEVIATION, d);
        chk("deviation", 32'h0, d);
        rd(ADDR_POSITION, d);
        chk("held position", p0 + 32'h2, d);
        clr <= 1'b0;
        wr(ADDR_PRESET, 32'h64);
        home <= 1'b1;
        repeat (10) @(posedge ref_clk_i);
        rd(ADDR_POSITION, d);
        chk("home", 32'h64, d);
        chk("stores", 32'h1, nv_seen);
        home <= 1'b0;
        preq <= 1'b1;
        repeat (6) @(posedge ref_clk_i);
        clr <= 1'b1;
        repeat (10) @(posedge ref_clk_i);
        rd(ADDR_SNAPSHOT, d);
        chk("snapshot", 32'h64, d);
        chk("clock pulse", 32'h1, pc_seen);
        clr <= 1'b0;
        preq <= 1'b0;
        $display("clear and home test done");
    endtask
    task automatic t_power();
        mp <= 1'b0;
        repeat (8) @(posedge ref_clk_i);
        ctrl.send(1, 1'b1, 1'b1);
        repeat (6) @(posedge ref_clk_i);
        chk("power error", 32'h1, {31'h0, alarm_o});
        clr <= 1'b1;
        repeat (8) @(posedge ref_clk_i);
        chk("fault clear", 32'h0, {31'h0, alarm_o});
        clr <= 1'b0;
        mp <= 1'b1;
        $display("power test done");
    endtask
    task automatic t_gear();
        wr(ADDR_GEAR, 32'h00010014);
        rd(ADDR_GEAR_EFF, d);
        chk("gear kept", 32'h00010001, d);
        rd(ADDR_STATUS, d);
        chk("gear warning", 32'h1, (d >> 6) & 32'h1);
        restart();
        chk("gear alarm", 32'h1, {31'h0, alarm_o});
        wr(ADDR_GEAR, 32'h0001000a);
        restart();
        chk("alarm gone", 32'h0, {31'h0, alarm_o});
        free <= 1'b1;
        repeat (10) @(posedge ref_clk_i);
        chk("free", 32'h1, {30'h0, motor_enable_o, brake_timing_output_o});
        free <= 1'b0;
        $display("gear test done");
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        repeat (3) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        repeat (8) @(posedge ref_clk_i);
        t_move();
        t_clear_home();
        t_power();
        t_gear();
        finish_test();
    end
    initial
    begin
        #100us;
        error_cnt++;
        finish_test();
    end
endmodule
`default_nettype wire
